// *** hdl/bis_boot_selector.sv ***
// Summary of operation
// - run system clock at 16 MHz internal RC for serial loaders and USB detection
// - after USB chosen, PLL from crystal makes 48 MHz USB and 32 MHz system
// - in USB loader keep clock failure monitor on; crystal loss causes reset
// - watchdog prescaler at maximum, refreshed periodically
// - loader program lives in 8 Kbyte region at 0x1FF00000
// - 4 Kbytes RAM at 0x20000000 reserved for loader use
// - serial frames are 8 data bits, even parity, one stop bit
// - second serial port uses its remapped pins
// - tick timer measures host signal to derive baud rate
// - low priority USB interrupt enabled and serves all DFU traffic
// - bank-two select or level 2: valid stack at 0x08080000 jumps bank two
// - same condition, no valid bank-two stack: valid stack at 0x08000000 jumps to bank one
// - level 2 with no valid stack halts the CPU for good
// - entering loader disables interrupts, then initialises clock, pins, watchdog, tick
// - USB cable seen without crystal gives a system reset
// - poll both serial ports; first to receive 0x7F is selected
// - USB with crystal: switch clocks to 32/48 MHz, run DFU from interrupts
`timescale 1ns/10ps
`default_nettype none
`include "bis_consts.svh"

module bis_boot_selector
  import bis_pkg::*;
#(
  parameter logic [31:0] SRAM_SIZE          = `BIS_SRAM_SIZE,
  parameter logic [31:0] WDG_REFRESH_CYCLES = `BIS_WDG_REFRESH_US * `BIS_CLK_MHZ
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        boot_bank_two_select,
  input  wire logic        protection_level_two,
  input  wire logic [31:0] bank_two_stack_word,
  input  wire logic [31:0] bank_one_stack_word,
  input  wire logic        serial_port_one_receive,
  input  wire logic        serial_port_two_receive,
  input  wire logic        usb_cable_detected,
  input  wire logic        external_crystal_clock_ready,
  input  wire logic        clock_failure_detected,
  output logic             jump_bank_two,
  output logic             jump_bank_one,
  output logic             cpu_halt,
  output logic             system_reset_request,
  output logic             irq_sources_disabled,
  output logic [31:0]      cpu_fetch_base,
  output logic             loader_ram_reserved,
  output logic [5:0]       system_clock_mhz,
  output logic [5:0]       usb_clock_mhz,
  output logic             pll_from_crystal,
  output logic             clock_failure_monitor_enable,
  output logic             usb_low_prio_irq_enable,
  output logic [2:0]       watchdog_prescaler,
  output logic             watchdog_refresh,
  output logic             serial_port_two_remap,
  output logic [1:0]       selected_interface,
  output logic             serial_loader_run,
  output logic             dfu_loader_run
);

  bis_regs_t r;
  bis_regs_t s;

  function automatic logic in_sram(input logic [31:0] w);
    in_sram = (w >= `BIS_RAM_BASE) && (w < (`BIS_RAM_BASE + SRAM_SIZE));
  endfunction : in_sram

  function automatic logic [7:0] word_addr(input logic [7:0] a);
    word_addr = {a[7:2], 2'b00};
  endfunction : word_addr

  function automatic logic is_loader(input bis_state_t state);
    is_loader = state inside {S_INIT, S_POLL, S_SERIAL, S_XTAL, S_RECLK, S_USB};
  endfunction : is_loader

  // autobaud receiver for one port; start bit width sets the bit time
  function automatic bis_port_t port_step(input bis_port_t p, input logic rxd);
    bis_port_t  n;
    logic [9:0] f;
    n     = p;
    f     = {rxd, p.shreg[9:1]};
    n.hit = 1'b0;
    case (p.ph)
      PH_IDLE: begin
        if (!rxd) begin
          n.ph  = PH_MEAS;
          n.cnt = 16'h0001;
        end
      end
      PH_MEAS: begin
        if (!rxd) begin
          if (p.cnt != 16'hffff) n.cnt = p.cnt + 16'h0001;
        end else if (p.cnt < `BIS_BAUD_MIN) begin
          n.ph = PH_IDLE; // glitch, too short to be a start bit
        end else begin
          n.width = p.cnt;
          n.cnt   = {1'b0, p.cnt[15:1]};
          n.bitn  = 4'h0;
          n.ph    = PH_SAMP;
        end
      end
      PH_SAMP: begin
        if (p.cnt != 16'h0000) begin
          n.cnt = p.cnt - 16'h0001;
        end else begin
          n.shreg = f;
          n.bitn  = p.bitn + 4'h1;
          n.cnt   = p.width - 16'h0001;
          if (p.bitn == `BIS_FRAME_BITS - 4'h1) begin
            n.ph  = PH_IDLE;
            n.hit = (f[7:0] == `BIS_SYNC_BYTE) && (f[8] == ^f[7:0]) && f[9];
          end
        end
      end
      default: n.ph = PH_IDLE;
    endcase
    return n;
  endfunction : port_step

  logic cable_s, xtal_s, cfail_s;

  assign cable_s = r.sy2[2];
  assign xtal_s  = r.sy2[3];
  assign cfail_s = r.sy2[4];

  assign s_axi_awready = !r.awv && !r.bvalid;
  assign s_axi_wready  = !r.wv && !r.bvalid;
  assign s_axi_arready = !r.rvalid;

  always_comb begin
    s          = r;
    s.sy1      = {clock_failure_detected, external_crystal_clock_ready,
                  usb_cable_detected, serial_port_two_receive, serial_port_one_receive};
    s.sy2      = r.sy1;
    s.wdg_kick = 1'b0;

    case (r.state)
      S_BOOT: begin
        if (boot_bank_two_select || protection_level_two) begin
          if (in_sram(bank_two_stack_word)) s.state = S_JUMP2;
          else if (in_sram(bank_one_stack_word)) s.state = S_JUMP1;
          else if (protection_level_two) s.state = S_HALT;
          else s.state = S_IRQOFF;
        end else begin
          s.state = S_IRQOFF;
        end
      end
      S_IRQOFF: s.state = S_INIT;
      S_INIT:   s.state = S_POLL;
      S_POLL: begin
        // receivers run only here, so a late claim cannot steal the link
        for (int i = 0; i < 2; i++) begin
          s.port[i] = port_step(r.port[i], r.sy2[i]);
        end
        if (r.ctrl[0] && cable_s) begin
          s.state = S_XTAL;
        end else if (r.ctrl[1] && s.port[0].hit) begin
          s.state = S_SERIAL;
          s.sel   = `BIS_SEL_SER1;
        end else if (r.ctrl[1] && s.port[1].hit) begin
          s.state = S_SERIAL;
          s.sel   = `BIS_SEL_SER2;
        end
      end
      S_XTAL:  s.state = xtal_s ? S_RECLK : S_RESET;
      S_RECLK: begin
        s.state = S_USB;
        s.sel   = `BIS_SEL_USB;
      end
      S_USB:   if (cfail_s) s.state = S_RESET;
      default: s.state = r.state;
    endcase

    // no stray kick in the cycle that leaves the loader
    if (is_loader(r.state) && is_loader(s.state)) begin
      if (r.wdg_cnt >= r.wdg_period - 32'h0000_0001) begin
        s.wdg_cnt  = 32'h0000_0000;
        s.wdg_kick = 1'b1;
      end else begin
        s.wdg_cnt = r.wdg_cnt + 32'h0000_0001;
      end
    end

    if (s_axi_awvalid && s_axi_awready) begin
      s.awv    = 1'b1;
      s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s.wv    = 1'b1;
      s.wdata = s_axi_wdata;
      s.wstrb = s_axi_wstrb;
    end
    if (r.awv && r.wv) begin
      s.awv    = 1'b0;
      s.wv     = 1'b0;
      s.bvalid = 1'b1;
      s.bresp  = `BIS_RESP_OKAY;
      case (word_addr(r.awaddr))
        `BIS_REG_STATUS, `BIS_REG_BAUD: s.bresp = `BIS_RESP_OKAY;
        `BIS_REG_CONTROL: begin
          if (r.wstrb[0]) s.ctrl = r.wdata[1:0];
        end
        `BIS_REG_WDG_PERIOD: begin
          for (int b = 0; b < 4; b++) begin
            if (r.wstrb[b]) s.wdg_period[8*b +: 8] = r.wdata[8*b +: 8];
          end
        end
        default: s.bresp = `BIS_RESP_SLVERR;
      endcase
    end else if (r.bvalid && s_axi_bready) begin
      s.bvalid = 1'b0;
    end

    if (s_axi_arvalid && s_axi_arready) begin
      s.rvalid = 1'b1;
      s.rresp  = `BIS_RESP_OKAY;
      case (word_addr(s_axi_araddr))
        `BIS_REG_STATUS:     s.rdata = {24'h00_0000, r.sel, xtal_s, cable_s, r.state};
        `BIS_REG_BAUD:       s.rdata = {16'h0000, (r.sel == `BIS_SEL_SER2) ?
                                        r.port[1].width : r.port[0].width};
        `BIS_REG_CONTROL:    s.rdata = {30'h0000_0000, r.ctrl};
        `BIS_REG_WDG_PERIOD: s.rdata = r.wdg_period;
        default: begin
          s.rdata = 32'h0000_0000;
          s.rresp = `BIS_RESP_SLVERR;
        end
      endcase
    end else if (r.rvalid && s_axi_rready) begin
      s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r            <= '0;
      r.ctrl       <= `BIS_CTRL_RESET;
      r.wdg_period <= WDG_REFRESH_CYCLES;
    end else begin
      r <= s;
    end
  end

  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp  = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata  = r.rdata;
  assign s_axi_rresp  = r.rresp;

  assign jump_bank_two        = (r.state == S_JUMP2);
  assign jump_bank_one        = (r.state == S_JUMP1);
  assign cpu_halt             = (r.state == S_HALT);
  assign system_reset_request = (r.state == S_RESET);
  assign irq_sources_disabled = !(r.state inside {S_BOOT, S_JUMP2, S_JUMP1, S_HALT});
  assign loader_ram_reserved  = irq_sources_disabled;
  assign cpu_fetch_base       = jump_bank_two ? `BIS_BANK2_BASE :
                                jump_bank_one ? `BIS_BANK1_BASE : `BIS_ROM_BASE;

  // pll only after the crystal has been confirmed
  assign pll_from_crystal  = (r.state == S_RECLK) || (r.state == S_USB);
  assign system_clock_mhz  = pll_from_crystal ? `BIS_SYS_PLL_MHZ : `BIS_INT_RC_MHZ;
  assign usb_clock_mhz     = pll_from_crystal ? `BIS_USB_MHZ : `BIS_NO_CLK_MHZ;
  assign clock_failure_monitor_enable = pll_from_crystal;
  assign usb_low_prio_irq_enable      = (r.state == S_USB);
  assign dfu_loader_run               = (r.state == S_USB);
  assign serial_loader_run            = (r.state == S_SERIAL);
  assign selected_interface           = r.sel;
  assign watchdog_prescaler = is_loader(r.state) ? `BIS_WDG_PRESC_MAX : `BIS_WDG_PRESC_OFF;
  assign watchdog_refresh   = r.wdg_kick;
  assign serial_port_two_remap = irq_sources_disabled;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence q_loader_init;
    (r.state == S_IRQOFF) && irq_sources_disabled
    ##1 (r.state == S_INIT) && (watchdog_prescaler == `BIS_WDG_PRESC_MAX)
    ##1 (r.state == S_POLL);
  endsequence

  sequence q_usb_clock;
    pll_from_crystal && (system_clock_mhz == `BIS_SYS_PLL_MHZ)
    ##1 dfu_loader_run && (usb_clock_mhz == `BIS_USB_MHZ);
  endsequence

  property p_bank_two;
    (r.state == S_BOOT) && (boot_bank_two_select || protection_level_two)
      && in_sram(bank_two_stack_word) |=> jump_bank_two && (cpu_fetch_base == `BIS_BANK2_BASE);
  endproperty
  a_bank_two: assert property (p_bank_two) else $error("bank two jump missed");

  property p_bank_one;
    (r.state == S_BOOT) && (boot_bank_two_select || protection_level_two)
      && !in_sram(bank_two_stack_word) && in_sram(bank_one_stack_word) |=> jump_bank_one;
  endproperty
  a_bank_one: assert property (p_bank_one) else $error("bank one jump missed");

  property p_halt;
    (r.state == S_BOOT) && protection_level_two && !in_sram(bank_two_stack_word)
      && !in_sram(bank_one_stack_word) |=> cpu_halt [*3];
  endproperty
  a_halt: assert property (p_halt) else $error("cpu not halted");

  property p_loader_entry;
    (r.state == S_BOOT) && !boot_bank_two_select && !protection_level_two |=> q_loader_init;
  endproperty
  a_loader_entry: assert property (p_loader_entry) else $error("loader entry order");

  property p_rc_clock;
    (serial_loader_run || (r.state == S_POLL)) |-> (system_clock_mhz == `BIS_INT_RC_MHZ);
  endproperty
  a_rc_clock: assert property (p_rc_clock) else $error("wrong clock in selection");

  property p_no_crystal;
    (r.state == S_POLL) && r.ctrl[0] && cable_s ##1 !xtal_s |=> system_reset_request;
  endproperty
  a_no_crystal: assert property (p_no_crystal) else $error("no reset without crystal");

  property p_usb_clock;
    (r.state == S_XTAL) && xtal_s |=> q_usb_clock;
  endproperty
  a_usb_clock: assert property (p_usb_clock) else $error("usb clock switch");

  property p_clock_fail;
    dfu_loader_run && cfail_s |-> clock_failure_monitor_enable ##1 system_reset_request;
  endproperty
  a_clock_fail: assert property (p_clock_fail) else $error("clock failure ignored");

  property p_port_claim;
    (r.state == S_POLL) && !(r.ctrl[0] && cable_s) && r.ctrl[1] && s.port[0].hit
      |=> serial_loader_run && (selected_interface == `BIS_SEL_SER1);
  endproperty
  a_port_claim: assert property (p_port_claim) else $error("serial claim missed");

  property p_locked;
    serial_loader_run |=> serial_loader_run && $stable(selected_interface);
  endproperty
  a_locked: assert property (p_locked) else $error("selection changed");

  property p_usb_irq;
    dfu_loader_run |-> usb_low_prio_irq_enable && irq_sources_disabled;
  endproperty
  a_usb_irq: assert property (p_usb_irq) else $error("usb irq not enabled");

  property p_wdg;
    watchdog_refresh |-> (watchdog_prescaler == `BIS_WDG_PRESC_MAX) ##1 !watchdog_refresh;
  endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog refresh malformed");

endmodule : bis_boot_selector
`default_nettype wire

// *** hdl/bis_consts.svh ***
`ifndef BIS_CONSTS_SVH
`define BIS_CONSTS_SVH

// clock rates
`define BIS_CLK_MHZ          32'h0000_0064
`define BIS_INT_RC_MHZ       6'h10
`define BIS_SYS_PLL_MHZ      6'h20
`define BIS_USB_MHZ          6'h30
`define BIS_NO_CLK_MHZ       6'h00

// watchdog
`define BIS_WDG_REFRESH_US   32'h0000_03e8
`define BIS_WDG_PRESC_MAX    3'h7
`define BIS_WDG_PRESC_OFF    3'h0

// memory map
`define BIS_ROM_BASE         32'h1ff0_0000
`define BIS_ROM_SIZE         32'h0000_2000
`define BIS_RAM_BASE         32'h2000_0000
`define BIS_RAM_LDR_SIZE     32'h0000_1000
`define BIS_SRAM_SIZE        32'h0000_c000
`define BIS_BANK1_BASE       32'h0800_0000
`define BIS_BANK2_BASE       32'h0808_0000

// serial frame: start, 8 data lsb first, even parity, 1 stop
`define BIS_SYNC_BYTE        8'h7f
`define BIS_FRAME_BITS       4'ha
`define BIS_BAUD_MIN         16'h0004

// interface selection codes
`define BIS_SEL_NONE         2'h0
`define BIS_SEL_SER1         2'h1
`define BIS_SEL_SER2         2'h2
`define BIS_SEL_USB          2'h3

// register bus
`define BIS_AXI_AW           8
`define BIS_REG_STATUS       8'h00
`define BIS_REG_BAUD         8'h04
`define BIS_REG_CONTROL      8'h08
`define BIS_REG_WDG_PERIOD   8'h0c
`define BIS_CTRL_RESET       2'h3
`define BIS_RESP_OKAY        2'h0
`define BIS_RESP_SLVERR      2'h2

`endif

// *** hdl/bis_pkg.sv ***
`default_nettype none
package bis_pkg;

  typedef enum logic [3:0] {
    S_BOOT, S_JUMP2, S_JUMP1, S_HALT, S_IRQOFF, S_INIT, S_POLL,
    S_SERIAL, S_XTAL, S_RECLK, S_USB, S_RESET
  } bis_state_t;

  typedef enum logic [1:0] {PH_IDLE, PH_MEAS, PH_SAMP} bis_phase_t;

  typedef struct packed {
    bis_phase_t  ph;
    logic [15:0] cnt;
    logic [15:0] width;
    logic [3:0]  bitn;
    logic [9:0]  shreg;
    logic        hit;
  } bis_port_t;

  typedef struct packed {
    bis_state_t      state;
    logic [1:0]      sel;
    bis_port_t [1:0] port;
    logic [4:0]      sy1;
    logic [4:0]      sy2;
    logic [31:0]     wdg_cnt;
    logic            wdg_kick;
    logic [1:0]      ctrl;
    logic [31:0]     wdg_period;
    logic            awv;
    logic [7:0]      awaddr;
    logic            wv;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
  } bis_regs_t;

endpackage : bis_pkg
`default_nettype wire

// *** bench/bis_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module bis_host_model (
  input  wire logic aclk,
  output logic      rx_one,
  output logic      rx_two
);
  // idle lines sit high between frames
  initial begin
    rx_one = 1'b1;
    rx_two = 1'b1;
  end

  // start, 8 data lsb first, even parity, one stop; par_ok low flips parity
  task automatic send_byte(input int port, input logic [7:0] b, input logic par_ok,
                           input int w);
    logic [9:0] fr;
    logic       v;
    fr = {1'b1, (^b) ^ !par_ok, b};
    @(posedge aclk);
    for (int i = 0; i < 11; i++) begin
      v = (i == 0) ? 1'b0 : fr[i-1];
      if (port == 1) rx_one <= v;
      else rx_two <= v;
      repeat (w) @(posedge aclk);
    end
  endtask : send_byte
endmodule : bis_host_model

`default_nettype wire

// *** bench/test_boot_interface_selector.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bis_consts.svh"

module test_boot_interface_selector;
  localparam logic [31:0] V   = `BIS_RAM_BASE;
  localparam logic [31:0] TOP = `BIS_RAM_BASE + `BIS_SRAM_SIZE;
  localparam int          WP  = 8;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, w2, w1, fbase, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, sel, rs;
  logic        bb2, lvl2, cable, xtal, cfail, rx1, rx2;
  logic        j2, j1, halt, sysrst, irqoff, ramres, pll, cfm, usbirq, wref, remap;
  logic        serrun, dfurun;
  logic [5:0]  sclk, uclk;
  logic [2:0]  wpresc;
  int          n_mismatch, n_checks, np;
  logic [31:0] exp_base [5] = '{32'h0808_0000, 32'h0808_0000, 32'h0800_0000,
                                `BIS_ROM_BASE, `BIS_ROM_BASE};
  int          exp_code [5] = '{0, 0, 1, 2, 3};

  bis_host_model host (.aclk(aclk), .rx_one(rx1), .rx_two(rx2));

  bis_boot_selector #(.WDG_REFRESH_CYCLES(WP)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .boot_bank_two_select(bb2), .protection_level_two(lvl2),
    .bank_two_stack_word(w2), .bank_one_stack_word(w1),
    .serial_port_one_receive(rx1), .serial_port_two_receive(rx2),
    .usb_cable_detected(cable), .external_crystal_clock_ready(xtal),
    .clock_failure_detected(cfail), .jump_bank_two(j2), .jump_bank_one(j1),
    .cpu_halt(halt), .system_reset_request(sysrst), .irq_sources_disabled(irqoff),
    .cpu_fetch_base(fbase), .loader_ram_reserved(ramres), .system_clock_mhz(sclk),
    .usb_clock_mhz(uclk), .pll_from_crystal(pll), .clock_failure_monitor_enable(cfm),
    .usb_low_prio_irq_enable(usbirq), .watchdog_prescaler(wpresc),
    .watchdog_refresh(wref), .serial_port_two_remap(remap),
    .selected_interface(sel), .serial_loader_run(serrun), .dfu_loader_run(dfurun)
  );

  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // bready and rready stay high, so only valids and payloads move here
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
  endtask : axi_read

  task automatic do_reset(input logic b2, input logic l2, input logic [31:0] s2,
                          input logic [31:0] s1);
    aresetn <= 1'b0;
    bb2 <= b2;
    lvl2 <= l2;
    w2 <= s2;
    w1 <= s1;
    cable <= 1'b0;
    xtal <= 1'b0;
    cfail <= 1'b0;
    cyc(12);
    check(fbase, `BIS_ROM_BASE);
    aresetn <= 1'b1;
    cyc(6);
  endtask : do_reset

  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    {aresetn, awvalid, wvalid, arvalid, bb2, lvl2, cable, xtal, cfail} = '0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata, wstrb, w2, w1} = '0;
    @(posedge aclk);
    // boot decision table, boundary stack words included
    for (int k = 0; k < 5; k++) begin
      do_reset(k != 1 && k != 3, k == 1 || k == 3, k == 0 ? V : k == 1 ? TOP - 4 :
               k == 3 ? 32'h1fff_fffc : TOP, k == 3 || k == 4 ? TOP : V);
      check(fbase, exp_base[k]);
      check({j2, j1, halt, irqoff}, 4'h8 >> exp_code[k]);
      if (k == 3) begin
        host.send_byte(1, `BIS_SYNC_BYTE, 1'b1, WP);
        cyc(2 * WP);
        check({halt, sel, wpresc}, {3'h4, `BIS_WDG_PRESC_OFF});
      end
    end
    // loader entered, still in poll
    check({sclk, uclk, pll}, {`BIS_INT_RC_MHZ, 6'h00, 1'b0});
    check({ramres, remap, wpresc}, {2'b11, `BIS_WDG_PRESC_MAX});
    axi_read(`BIS_REG_STATUS, rd, rs);
    check(rd[3:0], 4'h6);
    axi_read(`BIS_REG_CONTROL, rd, rs);
    check(rd, `BIS_CTRL_RESET);
    axi_read(`BIS_REG_WDG_PERIOD, rd, rs);
    check(rd, WP);
    axi_read(8'h10, rd, rs);
    check(rd, 32'h0000_0000);
    check(rs, `BIS_RESP_SLVERR);
    axi_write(`BIS_REG_STATUS, 32'hffff_ffff, rs);
    check(rs, `BIS_RESP_OKAY);
    axi_read(`BIS_REG_STATUS, rd, rs);
    check(rd, 32'h0000_0006);
    np = 0;
    repeat (4 * WP) begin
      @(posedge aclk);
      if (wref === 1'b1) np++;
    end
    check(np, 4);
    axi_write(`BIS_REG_WDG_PERIOD, 32'h0, rs);
    np = 0;
    repeat (4 * WP) begin
      @(posedge aclk);
      if (wref === 1'b1) np++;
    end
    check(np, 0);
    // usb detect off: cable ignored, serial claims only
    axi_write(`BIS_REG_CONTROL, 32'h2, rs);
    xtal <= 1'b1;
    cable <= 1'b1;
    cyc(10);
    check(sel, `BIS_SEL_NONE);
    host.send_byte(1, `BIS_SYNC_BYTE, 1'b1, 3);
    cyc(2 * WP);
    check(sel, `BIS_SEL_NONE);
    host.send_byte(2, `BIS_SYNC_BYTE, 1'b0, WP);
    cyc(2 * WP);
    check(sel, `BIS_SEL_NONE);
    host.send_byte(2, `BIS_SYNC_BYTE, 1'b1, WP);
    cyc(2 * WP);
    check({sel, serrun}, {`BIS_SEL_SER2, 1'b1});
    axi_read(`BIS_REG_BAUD, rd, rs);
    check(rd, WP);
    axi_write(`BIS_REG_CONTROL, 32'h3, rs);
    host.send_byte(1, `BIS_SYNC_BYTE, 1'b1, WP);
    cyc(2 * WP);
    check({sel, dfurun, sclk}, {`BIS_SEL_SER2, 1'b0, `BIS_INT_RC_MHZ});
    // usb with crystal, then crystal failure
    do_reset(1'b0, 1'b0, TOP, TOP);
    xtal <= 1'b1;
    cable <= 1'b1;
    cyc(10);
    check({sel, dfurun, usbirq, pll, cfm}, {`BIS_SEL_USB, 4'hf});
    check({sclk, uclk, sysrst}, {`BIS_SYS_PLL_MHZ, `BIS_USB_MHZ, 1'b0});
    host.send_byte(1, `BIS_SYNC_BYTE, 1'b1, WP);
    cyc(2 * WP);
    check({sel, serrun}, {`BIS_SEL_USB, 1'b0});
    cfail <= 1'b1;
    cyc(6);
    check(sysrst, 1'b1);
    // cable without crystal
    do_reset(1'b0, 1'b0, TOP, TOP);
    cable <= 1'b1;
    cyc(10);
    check({sysrst, dfurun, pll}, 3'h4);
    complete_run();
  end
endmodule : test_boot_interface_selector

`default_nettype wire
